// ===== fosr_map.svh
// Timing counts, encodings and reset values of the fail output and reset block
`ifndef FOSR_MAP_SVH
`define FOSR_MAP_SVH
`define FOSR_CLK_HZ          50000000
`define FOSR_BLINK_MHZ       1250
`define FOSR_BLINK_HALF      (`FOSR_CLK_HZ / 2 * 1000 / `FOSR_BLINK_MHZ)
`define FOSR_PWM_HZ          100
`define FOSR_PWM_PERIOD      (`FOSR_CLK_HZ / `FOSR_PWM_HZ)
`define FOSR_TEST_FILT_US    64
`define FOSR_TEST_FILT_CYC   (`FOSR_TEST_FILT_US * (`FOSR_CLK_HZ / 1000000))
`define FOSR_RF_NS           4000
`define FOSR_RF_CYC          ((`FOSR_RF_NS * (`FOSR_CLK_HZ / 1000000)) / 1000)
`define FOSR_RD_US           10000
`define FOSR_RD_CYC          (`FOSR_RD_US * (`FOSR_CLK_HZ / 1000000))
`define FOSR_DUTY_RST        2'h0
`define FOSR_THR_RST         2'h0
`define FOSR_CFG_RST         2'h0
`define FOSR_MODE_SOFT_RST   2'h3
`endif

// ===== fosr_pkg.sv
// Types of the fail output and reset block
package fosr_pkg;
  typedef enum logic [2:0] {
    SBC_INIT     = 3'h0,
    SBC_NORMAL   = 3'h1,
    SBC_STOP     = 3'h2,
    SBC_SLEEP    = 3'h3,
    SBC_RESTART  = 3'h4,
    SBC_FAILSAFE = 3'h5
  } fosr_mode_t;
  typedef enum logic [1:0] {
    PIN_FAIL = 2'h0,
    PIN_OFF  = 2'h1,
    PIN_WAKE = 2'h2,
    PIN_LS   = 2'h3
  } fosr_pin_cfg_t;
endpackage

// ===== fosr_top.sv
// Fail outputs, alternate pin functions, test strap and reset output
`timescale 1ns/1ps
`include "fosr_map.svh"
module fosr_top #(
  parameter int unsigned BLINK_HALF = `FOSR_BLINK_HALF,
  parameter int unsigned PWM_PERIOD = `FOSR_PWM_PERIOD,
  parameter int unsigned RD_CYC     = `FOSR_RD_CYC
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] mode_state,
  input  wire logic       failure_event,
  input  wire logic       failure_present,
  input  wire logic       failure_flag_clr,
  input  wire logic       wd_trigger_fail,
  input  wire logic       vcc_undervolt,
  input  wire logic       vcc_good,
  input  wire logic       soft_reset_cmd,
  input  wire logic [1:0] mode_field_wr,
  input  wire logic       soft_reset_pulse_select,
  input  wire logic [1:0] pwm_fail_duty_field,
  input  wire logic       pin_cfg_wr,
  input  wire logic [1:0] blink_cfg_wr,
  input  wire logic [1:0] pwm_cfg_wr,
  input  wire logic       blink_hs_sel,
  input  wire logic       pwm_hs_sel,
  input  wire logic [1:0] reset_thr_wr,
  input  wire logic       reset_thr_we,
  input  wire logic       test_pin_in,
  input  wire logic       init_phase,
  output logic            static_fail_pin_n,
  output logic            blink_fail_pin_n,
  output logic            pwm_fail_test_pin_n,
  output logic            blink_wake_en,
  output logic            pwm_wake_en,
  output logic            blink_sw_on,
  output logic            pwm_sw_on,
  output logic            reset_out_pin_n,
  output logic            failure_flag,
  output logic            dev_mode,
  output logic            soft_reset_done,
  output logic [1:0]      reset_thr_sel
);
  typedef struct packed {
    logic [1:0]  blink_cfg;
    logic        blink_hs;
    logic [1:0]  pwm_cfg;
    logic        pwm_hs;
    logic [1:0]  duty;
    logic [1:0]  thr;
    logic        fail_act;
    logic        flag;
    logic [31:0] blink_cnt;
    logic        blink_ph;
    logic [31:0] pwm_cnt;
    logic [31:0] test_cnt;
    logic        test_done;
    logic        dev;
    logic [31:0] rf_cnt;
    logic [31:0] rd_cnt;
    logic        ro_low;
    logic        sr_done;
    logic        o_static;
    logic        o_blink;
    logic        o_pwm;
    logic        o_bwake;
    logic        o_pwake;
    logic        o_bsw;
    logic        o_psw;
  } fosr_state_t;

  fosr_state_t st_reg;
  fosr_state_t st_next;

  default clocking fosr_cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // PWM high time for the chosen duty
  function automatic logic [31:0] duty_cyc(input logic [1:0] d);
    logic [31:0] base;
    base = PWM_PERIOD / 5;
    unique case (d)
      2'h0: duty_cyc = base;
      2'h1: duty_cyc = base / 2;
      2'h2: duty_cyc = base / 4;
      2'h3: duty_cyc = base / 8;
    endcase
  endfunction

  // Pin drive for a fail-capable GPIO given its pin config and fail state
  function automatic logic gp_fail(input logic [1:0] c, input logic act);
    gp_fail = (c == fosr_pkg::PIN_FAIL) && act;
  endfunction

  logic       reset_src;
  logic       sr_exec;
  logic       in_nrm;
  logic       rst_mode;
  logic [2:0] md;

  always_comb begin
    md       = mode_state;
    in_nrm   = (md == fosr_pkg::SBC_NORMAL);
    rst_mode = (md == fosr_pkg::SBC_RESTART) || (md == fosr_pkg::SBC_FAILSAFE);
    sr_exec  = soft_reset_cmd && (mode_field_wr == `FOSR_MODE_SOFT_RST)
               && (in_nrm || md == fosr_pkg::SBC_STOP);
    reset_src = vcc_undervolt || !vcc_good || wd_trigger_fail;
  end

  always_comb begin
    st_next = st_reg;
    st_next.sr_done = 1'b0;
    // Pin config only in normal mode, held elsewhere except soft reset defaults; threshold written in any mode
    if (pin_cfg_wr && in_nrm) begin
      st_next.blink_cfg = blink_cfg_wr;
      st_next.pwm_cfg   = pwm_cfg_wr;
      st_next.blink_hs  = blink_hs_sel;
      st_next.pwm_hs    = pwm_hs_sel;
      st_next.duty      = pwm_fail_duty_field;
    end
    if (reset_thr_we)
      st_next.thr = reset_thr_wr;
    // Failure latch; set wins over clear
    if (failure_event) begin
      st_next.fail_act = 1'b1;
      st_next.flag     = 1'b1;
    end else begin
      if (failure_flag_clr)
        st_next.flag = 1'b0;
      if (in_nrm && !failure_present && !st_reg.flag)
        st_next.fail_act = 1'b0;
    end
    // Blink and PWM counters from oscillator
    if (st_reg.blink_cnt >= BLINK_HALF - 1) begin
      st_next.blink_cnt = 32'h0;
      st_next.blink_ph  = !st_reg.blink_ph;
    end else begin
      st_next.blink_cnt = st_reg.blink_cnt + 32'h1;
    end
    if (st_reg.pwm_cnt >= PWM_PERIOD - 1)
      st_next.pwm_cnt = 32'h0;
    else
      st_next.pwm_cnt = st_reg.pwm_cnt + 32'h1;
    // Test strap filter during init
    if (init_phase && !st_reg.test_done) begin
      if (test_pin_in) begin
        st_next.test_done = 1'b1;
        st_next.dev       = 1'b0;
      end else if (st_reg.test_cnt >= `FOSR_TEST_FILT_CYC - 1) begin
        st_next.test_done = 1'b1;
        st_next.dev       = 1'b1;
      end else begin
        st_next.test_cnt = st_reg.test_cnt + 32'h1;
      end
    end
    // Reset output: filter, hold, release delay
    if (reset_src) begin
      st_next.rd_cnt = 32'h0;
      if (st_reg.rf_cnt >= `FOSR_RF_CYC - 1)
        st_next.ro_low = 1'b1;
      else
        st_next.rf_cnt = st_reg.rf_cnt + 32'h1;
    end else begin
      st_next.rf_cnt = 32'h0;
      if (st_reg.ro_low) begin
        if (st_reg.rd_cnt >= RD_CYC - 1) begin
          st_next.ro_low = 1'b0;
          st_next.rd_cnt = 32'h0;
        end else begin
          st_next.rd_cnt = st_reg.rd_cnt + 32'h1;
        end
      end
    end
    if (sr_exec) begin
      st_next.blink_cfg = `FOSR_CFG_RST;
      st_next.pwm_cfg   = `FOSR_CFG_RST;
      st_next.blink_hs  = 1'b0;
      st_next.pwm_hs    = 1'b0;
      st_next.duty      = `FOSR_DUTY_RST;
      st_next.thr       = `FOSR_THR_RST;
      st_next.sr_done   = 1'b1;
      if (!soft_reset_pulse_select) begin
        st_next.ro_low = 1'b1;
        st_next.rd_cnt = 32'h0;
      end
    end
    // Output pin functions per mode
    st_next.o_static = st_reg.fail_act;
    st_next.o_blink  = gp_fail(st_reg.blink_cfg, st_reg.fail_act)
                       && st_reg.blink_ph;
    st_next.o_pwm    = gp_fail(st_reg.pwm_cfg, st_reg.fail_act)
                       && (st_reg.pwm_cnt < duty_cyc(st_reg.duty));
    st_next.o_bwake  = (st_reg.blink_cfg == fosr_pkg::PIN_WAKE)
                       && (md != fosr_pkg::SBC_FAILSAFE);
    st_next.o_pwake  = (st_reg.pwm_cfg == fosr_pkg::PIN_WAKE)
                       && (md != fosr_pkg::SBC_FAILSAFE);
    st_next.o_bsw    = (st_reg.blink_cfg == fosr_pkg::PIN_LS) && !rst_mode;
    st_next.o_psw    = (st_reg.pwm_cfg == fosr_pkg::PIN_LS) && !rst_mode;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg           <= '0;
      st_reg.blink_cfg <= `FOSR_CFG_RST;
      st_reg.pwm_cfg   <= `FOSR_CFG_RST;
      st_reg.duty      <= `FOSR_DUTY_RST;
      st_reg.thr       <= `FOSR_THR_RST;
      st_reg.ro_low    <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Active-low pins and flags straight from the state flops
  assign static_fail_pin_n   = !st_reg.o_static;
  assign blink_fail_pin_n    = !st_reg.o_blink;
  assign pwm_fail_test_pin_n = !st_reg.o_pwm;
  assign blink_wake_en       = st_reg.o_bwake;
  assign pwm_wake_en         = st_reg.o_pwake;
  assign blink_sw_on         = st_reg.o_bsw;
  assign pwm_sw_on           = st_reg.o_psw;
  assign reset_out_pin_n     = !st_reg.ro_low;
  assign failure_flag        = st_reg.flag;
  assign dev_mode            = st_reg.dev;
  assign soft_reset_done     = st_reg.sr_done;
  assign reset_thr_sel       = st_reg.thr;

  sequence s_fail_ev;
    failure_event;
  endsequence
  sequence s_fail_out;
    ##2 !static_fail_pin_n;
  endsequence
  // Pattern states one cycle before the pin follows
  sequence s_blink_armed;
    st_reg.fail_act && (st_reg.blink_cfg == fosr_pkg::PIN_FAIL);
  endsequence
  sequence s_pwm_off_slot;
    st_reg.fail_act && (st_reg.pwm_cfg == fosr_pkg::PIN_FAIL)
      && (st_reg.pwm_cnt >= duty_cyc(st_reg.duty));
  endsequence
  sequence s_sr_pulse;
    sr_exec && !soft_reset_pulse_select;
  endsequence
  sequence s_sr_seen;
    !reset_out_pin_n && soft_reset_done;
  endsequence
  sequence s_rd_running;
    !reset_src && !sr_exec && st_reg.ro_low;
  endsequence

  a_fail_activates: assert property (s_fail_ev |-> s_fail_out)
    else $error("fail output not activated");
  a_flag_sets: assert property (failure_event |=> failure_flag)
    else $error("failure flag not set");
  a_cfg_hold: assert property ((!in_nrm && !sr_exec)
    |=> $stable(st_reg.blink_cfg))
    else $error("config changed outside normal mode");
  a_off_quiet: assert property (st_reg.blink_cfg == fosr_pkg::PIN_OFF
    |=> blink_fail_pin_n)
    else $error("off pin driven");
  a_sw_restart: assert property (rst_mode
    |=> !blink_sw_on && !pwm_sw_on)
    else $error("switch on in restart");
  a_wake_fs: assert property ((md == fosr_pkg::SBC_FAILSAFE)
    |=> !blink_wake_en)
    else $error("wake enabled in fail-safe");
  a_ro_hold: assert property ((reset_src && !reset_out_pin_n)
    |=> !reset_out_pin_n)
    else $error("reset released during event");
  a_sr_ignored: assert property ((soft_reset_cmd && !in_nrm
    && md != fosr_pkg::SBC_STOP) |=> !soft_reset_done)
    else $error("soft reset executed in wrong mode");
  a_fail_stays: assert property ((st_reg.fail_act && !in_nrm)
    |=> st_reg.fail_act)
    else $error("fail output dropped outside normal");

  // Blink and PWM patterns
  a_blink_follow: assert property (s_blink_armed
    |=> (blink_fail_pin_n == !$past(st_reg.blink_ph)))
    else $error("blink pin off its phase");
  a_blink_toggle: assert property ((st_reg.blink_cnt >= BLINK_HALF - 1)
    |=> (st_reg.blink_ph != $past(st_reg.blink_ph)))
    else $error("blink phase did not toggle");
  a_blink_bound: assert property (st_reg.blink_cnt < BLINK_HALF)
    else $error("blink counter out of range");
  a_pwm_bound: assert property (st_reg.pwm_cnt < PWM_PERIOD)
    else $error("pwm counter out of range");
  a_pwm_duty: assert property (s_pwm_off_slot |=> pwm_fail_test_pin_n)
    else $error("pwm pin active outside duty slot");
  a_off_pwm: assert property (st_reg.pwm_cfg == fosr_pkg::PIN_OFF
    |=> pwm_fail_test_pin_n)
    else $error("off pwm pin driven");

  // Test strap
  a_dev_user: assert property ((init_phase && !st_reg.test_done
    && test_pin_in) |=> !dev_mode)
    else $error("development mode with strap high");
  a_dev_filter: assert property ((init_phase && !st_reg.test_done
    && !test_pin_in && st_reg.test_cnt >= `FOSR_TEST_FILT_CYC - 1)
    |=> dev_mode)
    else $error("development mode not selected");

  // Reset output
  a_ro_filter: assert property ((reset_src && reset_out_pin_n
    && st_reg.rf_cnt < `FOSR_RF_CYC - 1
    && !(sr_exec && !soft_reset_pulse_select)) |=> reset_out_pin_n)
    else $error("reset output before filter time");
  a_ro_release: assert property (s_rd_running
    ##0 (st_reg.rd_cnt >= RD_CYC - 1) |=> reset_out_pin_n)
    else $error("reset output not released");
  a_ro_delay: assert property (s_rd_running
    ##0 (st_reg.rd_cnt < RD_CYC - 1) |=> !reset_out_pin_n)
    else $error("reset output released early");
  a_sr_pulse: assert property (s_sr_pulse |=> s_sr_seen)
    else $error("soft reset did not pulse reset output");
  a_sr_no_pulse: assert property ((sr_exec && soft_reset_pulse_select
    && !reset_src && !st_reg.ro_low) |=> reset_out_pin_n)
    else $error("soft reset touched reset output");
  a_sr_defaults: assert property (sr_exec
    |=> (reset_thr_sel == `FOSR_THR_RST)
    && (st_reg.blink_cfg == `FOSR_CFG_RST)
    && (st_reg.pwm_cfg == `FOSR_CFG_RST))
    else $error("soft reset left settings");
  a_thr_write: assert property ((reset_thr_we && !sr_exec)
    |=> (reset_thr_sel == $past(reset_thr_wr)))
    else $error("threshold write lost");

  // Failure flag and pin functions
  a_flag_clr: assert property ((failure_flag_clr && !failure_event)
    |=> !failure_flag)
    else $error("failure flag not cleared");
  a_fail_clear: assert property ((in_nrm && !failure_present
    && !st_reg.flag && !failure_event) |=> !st_reg.fail_act)
    else $error("fail outputs not released");
  a_hs_hold: assert property ((!in_nrm && !sr_exec)
    |=> $stable(st_reg.blink_hs) && $stable(st_reg.pwm_hs)
    && $stable(st_reg.pwm_cfg))
    else $error("pin setting changed outside normal mode");
  a_wake_restart: assert property ((md == fosr_pkg::SBC_RESTART
    && st_reg.blink_cfg == fosr_pkg::PIN_WAKE) |=> blink_wake_en)
    else $error("wake lost in restart");
  a_pwake_fs: assert property ((md == fosr_pkg::SBC_FAILSAFE)
    |=> !pwm_wake_en)
    else $error("pwm wake enabled in fail-safe");
  a_sw_resume: assert property ((st_reg.blink_cfg == fosr_pkg::PIN_LS
    && !rst_mode) |=> blink_sw_on)
    else $error("switch not resumed");
endmodule // fosr_top

// ===== fosr_host_model.sv
// Host side model: test strap level and mode write strobe
`timescale 1ns/1ps
module fosr_host_model (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       dev_req,
  input  wire logic       sr_req,
  input  wire logic [1:0] sr_mode,
  output logic            test_pin_in,
  output logic            soft_reset_cmd,
  output logic [1:0]      mode_field_wr
);
  // Strap stays high unless development mode is wanted
  assign test_pin_in = !dev_req;
  // One-cycle strobe; idle value is the inverse of the mode
  always_ff @(posedge mclk) begin
    soft_reset_cmd <= sr_req && !sys_rst;
    mode_field_wr  <= sr_req ? sr_mode : ~sr_mode;
  end
endmodule // fosr_host_model

// ===== tb.sv
// Self-checking bench of the fail output and reset block
`timescale 1ns/1ps
module tb;
  localparam int BH = 8;
  localparam int PP = 80;
  localparam int RD = 20;
  logic mclk = 1'b0, sys_rst = 1'b1, dev_req = 1'b1, sr_req = 1'b0;
  logic [2:0] mode_state = fosr_pkg::SBC_INIT;
  logic fev = 1'b0, fpr = 1'b0, fclr = 1'b0, wdf = 1'b0, uv = 1'b0;
  logic vgood = 1'b1, sel = 1'b0, cwr = 1'b0, twe = 1'b0, initp = 1'b1;
  logic [1:0] duty = 2'h0, bcfg = 2'h0, pcfg = 2'h0, twr = 2'h0;
  logic [1:0] sr_mode = 2'h3, mfw, thr;
  logic tpin, scmd, sfp, bfp, pfp, bwk, pwk, bsw, psw, rop, flag, dev, done;
  int err_total = 0, total_checks = 0, n, lb, lp;
  always #10 mclk = ~mclk;
  fosr_host_model u_host (.mclk(mclk), .sys_rst(sys_rst),
    .dev_req(dev_req), .sr_req(sr_req), .sr_mode(sr_mode),
    .test_pin_in(tpin), .soft_reset_cmd(scmd), .mode_field_wr(mfw));
  fosr_top #(.BLINK_HALF(BH), .PWM_PERIOD(PP), .RD_CYC(RD)) u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .mode_state(mode_state),
    .failure_event(fev), .failure_present(fpr), .failure_flag_clr(fclr),
    .wd_trigger_fail(wdf), .vcc_undervolt(uv), .vcc_good(vgood),
    .soft_reset_cmd(scmd), .mode_field_wr(mfw),
    .soft_reset_pulse_select(sel), .pwm_fail_duty_field(duty),
    .pin_cfg_wr(cwr), .blink_cfg_wr(bcfg), .pwm_cfg_wr(pcfg),
    .blink_hs_sel(1'b0), .pwm_hs_sel(1'b1), .reset_thr_wr(twr),
    .reset_thr_we(twe), .test_pin_in(tpin), .init_phase(initp),
    .static_fail_pin_n(sfp), .blink_fail_pin_n(bfp),
    .pwm_fail_test_pin_n(pfp), .blink_wake_en(bwk), .pwm_wake_en(pwk),
    .blink_sw_on(bsw), .pwm_sw_on(psw), .reset_out_pin_n(rop),
    .failure_flag(flag), .dev_mode(dev), .soft_reset_done(done),
    .reset_thr_sel(thr));
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int v, input int lo, input int hi);
    total_checks++;
    if (v < lo || v > hi) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, v, lo);
    end
  endtask
  task automatic wait_ro(input logic lvl, output int k);
    k = 0;
    while (rop !== lvl && k < 1000) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(2);
  endtask
  task automatic cfg(input logic [1:0] b, input logic [1:0] p,
                     input logic [1:0] d);
    bcfg = b;
    pcfg = p;
    duty = d;
    pulse(cwr);
  endtask
  task automatic cnt(input int k);
    lb = 0;
    lp = 0;
    repeat (k) begin
      lb += (bfp === 1'b0);
      lp += (pfp === 1'b0);
      cyc(1);
    end
  endtask
  task automatic sr_try(input logic [2:0] m, input logic [7:0] exp);
    mode_state = m;
    n = 0;
    sr_req = 1'b1;
    cyc(1);
    sr_req = 1'b0;
    repeat (5) begin
      n += (done === 1'b1);
      cyc(1);
    end
    chk(n, exp);
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #500000;
    err_total++;
    conclude();
  end
  initial begin
    cyc(6);
    sys_rst = 1'b0;
    chk({sfp, bfp, pfp, rop, flag}, 8'h1C);
    wait_ro(1'b1, n);
    chk_rng(n, RD - 2, RD + 3);
    cyc(3300);
    initp = 1'b0;
    dev_req = 1'b0;
    chk(dev, 8'h01);
    twr = 2'h2;
    pulse(twe);
    chk(thr, 8'h02);
    $display("test reset and strap done");
    mode_state = fosr_pkg::SBC_NORMAL;
    cfg(fosr_pkg::PIN_WAKE, fosr_pkg::PIN_LS, 2'h0);
    chk({bwk, psw}, 8'h03);
    mode_state = fosr_pkg::SBC_STOP;
    cfg(fosr_pkg::PIN_FAIL, fosr_pkg::PIN_FAIL, 2'h0);
    chk({bwk, psw}, 8'h03);
    mode_state = fosr_pkg::SBC_SLEEP;
    cyc(2);
    chk({bwk, psw}, 8'h03);
    mode_state = fosr_pkg::SBC_NORMAL;
    fpr = 1'b1;
    pulse(fev);
    mode_state = fosr_pkg::SBC_RESTART;
    cyc(2);
    chk({bwk, psw, sfp, flag}, 8'h09);
    mode_state = fosr_pkg::SBC_FAILSAFE;
    cyc(2);
    chk({bwk, psw, sfp, flag}, 8'h01);
    mode_state = fosr_pkg::SBC_NORMAL;
    cyc(2);
    chk({bwk, psw, sfp, flag}, 8'h0D);
    pulse(fclr);
    chk(sfp, 8'h00);
    fpr = 1'b0;
    pulse(fclr);
    chk({sfp, flag}, 8'h02);
    cfg(fosr_pkg::PIN_LS, fosr_pkg::PIN_WAKE, 2'h0);
    chk({pwk, bsw, bwk, psw}, 8'h0C);
    $display("test pin functions done");
    cfg(fosr_pkg::PIN_FAIL, fosr_pkg::PIN_OFF, 2'h0);
    fpr = 1'b1;
    pulse(fev);
    cnt(8 * BH);
    chk(lb, 4 * BH);
    chk(lp, 8'h00);
    for (int d = 0; d < 4; d++) begin
      cfg(fosr_pkg::PIN_OFF, fosr_pkg::PIN_FAIL, d[1:0]);
      cnt(PP);
      chk(lp, (PP / 5) >> d);
      chk(lb, 8'h00);
    end
    fpr = 1'b0;
    pulse(fclr);
    $display("test patterns done");
    sel = 1'b1;
    sr_try(fosr_pkg::SBC_INIT, 8'h00);
    sr_try(fosr_pkg::SBC_SLEEP, 8'h00);
    sr_try(fosr_pkg::SBC_RESTART, 8'h00);
    sr_try(fosr_pkg::SBC_FAILSAFE, 8'h00);
    sr_try(fosr_pkg::SBC_STOP, 8'h01);
    chk({rop, thr}, 8'h04);
    sr_mode = 2'h1;
    sr_try(fosr_pkg::SBC_NORMAL, 8'h00);
    sr_mode = 2'h3;
    sel = 1'b0;
    sr_try(fosr_pkg::SBC_NORMAL, 8'h01);
    chk(rop, 8'h00);
    wait_ro(1'b1, n);
    chk_rng(n, RD - 8, RD + 3);
    $display("test soft reset done");
    for (int s = 0; s < 2; s++) begin
      wdf = (s == 0);
      uv = (s == 1);
      wait_ro(1'b0, n);
      chk_rng(n, 198, 203);
      cyc(20);
      wdf = 1'b0;
      uv = 1'b0;
      wait_ro(1'b1, n);
      chk_rng(n, RD - 2, RD + 3);
    end
    $display("test reset sources done");
    sys_rst = 1'b1;
    vgood = 1'b0;
    initp = 1'b1;
    cyc(6);
    sys_rst = 1'b0;
    cyc(50);
    chk({rop, dev, thr}, 8'h00);
    vgood = 1'b1;
    wait_ro(1'b1, n);
    chk_rng(n, RD - 2, RD + 3);
    $display("test second reset done");
    conclude();
  end
endmodule // tb
